// ==== common/sfs_pkg.sv ====
// constants shared by the serial fifo status and control block
`default_nettype none
package sfs_pkg;
	// register byte addresses
	localparam logic [31:0] FIFO_STATUS_ADDR    = 32'h5000107C;
	localparam logic [31:0] TX_FILL_LEVEL_ADDR  = 32'h50001080;
	localparam logic [31:0] RX_FILL_LEVEL_ADDR  = 32'h50001084;
	localparam logic [31:0] SOFT_RESET_ADDR     = 32'h50001088;
	localparam logic [31:0] SEND_REQ_SHADOW_ADDR = 32'h5000108C;
	localparam logic [31:0] IRQ_STATUS_ADDR     = 32'h500010C0;
	localparam logic [31:0] IRQ_MASK_ADDR       = 32'h500010C4;

	// fifo_status field positions
	localparam int RX_FULL_BIT      = 4;
	localparam int RX_NOT_EMPTY_BIT = 3;
	localparam int TX_EMPTY_BIT     = 2;
	localparam int TX_NOT_FULL_BIT  = 1;

	// field widths of the fill level registers
	localparam int TX_LEVEL_W = 6;
	localparam int RX_LEVEL_W = 16;

	// software_reset_control field positions
	localparam int TX_FLUSH_BIT   = 2;
	localparam int RX_FLUSH_BIT   = 1;
	localparam int SOFT_RESET_BIT = 0;

	// shadow_send_request field position
	localparam int SEND_REQ_BIT = 0;

	// interrupt status and mask field positions
	localparam int IRQ_W            = 4;
	localparam int IRQ_RX_FULL_BIT  = 0;
	localparam int IRQ_TX_EMPTY_BIT = 1;
	localparam int IRQ_RX_OVF_BIT   = 2;
	localparam int IRQ_TX_OVF_BIT   = 3;

	// reset values
	localparam logic             SEND_REQ_RST = 1'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// default fifo depth
	localparam int FIFO_DEPTH_DEF = 16;
endpackage : sfs_pkg
`default_nettype wire

// ==== logic/_unused_placeholder_removed.sv ====
// intentionally empty file holder
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== logic/sfs_serial_fifo_status.sv ====
// fifo status, fill levels, soft reset and send request control
//
// Operation
// - status bit 4 reads 1 while the receive fifo is full, else 0, reset 0.
// - status bit 3 reads 1 while the receive fifo holds any entry.
// - status bit 2 reads 1 while the transmit fifo is empty, reset 1.
// - status bit 1 reads 1 while the transmit fifo has room, reset 1.
// - transmit level bits 5:0 show the transmit entry count, reset 0.
// - receive level bits 15:0 show the receive entry count, reset 0.
// - writing 1 to reset bit 2 empties the transmit fifo, self clearing.
// - writing 1 to reset bit 1 empties the receive fifo, self clearing.
// - writing 1 to reset bit 0 resets the controller async, release sync.
// - shadow send request bit 0 is the same state as the modem send bit.
// - without auto flow or loopback the send request pin is low exactly when set.
// - with auto flow and fifos on, fill above threshold forces it high.
// - in loopback the pin is held high and the bit is looped inside.
// - fifo enable switches fifos; clearing it after set flushes both.
// - loopback is chosen by the modem control loopback bit.
`timescale 1ns/1ns
`default_nettype none
module sfs_serial_fifo_status #(
	parameter int TX_DEPTH = sfs_pkg::FIFO_DEPTH_DEF,
	parameter int RX_DEPTH = sfs_pkg::FIFO_DEPTH_DEF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// fifo traffic from the serial port
	input  wire logic        txPush,
	input  wire logic        txPop,
	input  wire logic        rxPush,
	input  wire logic        rxPop,
	// fifo_control and modem_control bits
	input  wire logic        fifoEnable,
	input  wire logic        ctlTxFlush,
	input  wire logic        ctlRxFlush,
	input  wire logic        autoFlowEnable,
	input  wire logic        loopbackEnable,
	input  wire logic        ctlSendReqWrite,
	input  wire logic        ctlSendReqData,
	input  wire logic        rxAboveThreshold,
	// controls to the serial port
	output var  logic        txFifoFlush,
	output var  logic        rxFifoFlush,
	output var  logic        controllerResetN,
	output var  logic        sendRequestBit,
	output var  logic        sendRequestN,
	output var  logic        loopSendRequest,
	output var  logic        irq
);
	localparam int TXC_W = $clog2(TX_DEPTH + 1);
	localparam int RXC_W = $clog2(RX_DEPTH + 1);
	localparam logic [TXC_W-1:0] TX_FULL_CNT = TXC_W'(TX_DEPTH);
	localparam logic [RXC_W-1:0] RX_FULL_CNT = RXC_W'(RX_DEPTH);

	// bus-side state, kept on reset_n so a soft reset never loses an answer; the two reset sync flops clear on ctrlArstN
	logic [31:0] awAddr_r;
	logic        awHeld_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        wHeld_r;
	logic        softResetReq_r;
	logic        rstSync1_r;
	logic        rstSync2_r;

	// controller state, reset by reset_n or soft reset
	logic [TXC_W-1:0] txCount_r;
	logic [TXC_W-1:0] txCount_nxt;
	logic [RXC_W-1:0] rxCount_r;
	logic [RXC_W-1:0] rxCount_nxt;
	logic             sendReq_r;
	logic             fifoEnPrev_r;
	logic [sfs_pkg::IRQ_W-1:0] irqStat_r;
	logic [sfs_pkg::IRQ_W-1:0] irqStat_nxt;
	logic [sfs_pkg::IRQ_W-1:0] irqMask_r;

	// write channel decode
	wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire lane0   = wStrb_r[0];
	wire wrSoft  = doWrite && lane0
		&& (awAddr_r == sfs_pkg::SOFT_RESET_ADDR);
	wire wrShadow = doWrite && lane0
		&& (awAddr_r == sfs_pkg::SEND_REQ_SHADOW_ADDR);
	wire wrMask  = doWrite && lane0
		&& (awAddr_r == sfs_pkg::IRQ_MASK_ADDR);
	wire wrKnown = (awAddr_r == sfs_pkg::FIFO_STATUS_ADDR)
		|| (awAddr_r == sfs_pkg::TX_FILL_LEVEL_ADDR)
		|| (awAddr_r == sfs_pkg::RX_FILL_LEVEL_ADDR)
		|| (awAddr_r == sfs_pkg::SOFT_RESET_ADDR)
		|| (awAddr_r == sfs_pkg::SEND_REQ_SHADOW_ADDR)
		|| (awAddr_r == sfs_pkg::IRQ_STATUS_ADDR)
		|| (awAddr_r == sfs_pkg::IRQ_MASK_ADDR);

	// read channel decode
	wire doRead = s_axi_arvalid && s_axi_arready;
	wire rdStatus = s_axi_araddr == sfs_pkg::FIFO_STATUS_ADDR;
	wire rdTxLvl  = s_axi_araddr == sfs_pkg::TX_FILL_LEVEL_ADDR;
	wire rdRxLvl  = s_axi_araddr == sfs_pkg::RX_FILL_LEVEL_ADDR;
	wire rdSoft   = s_axi_araddr == sfs_pkg::SOFT_RESET_ADDR;
	wire rdShadow = s_axi_araddr == sfs_pkg::SEND_REQ_SHADOW_ADDR;
	wire rdIrqSt  = s_axi_araddr == sfs_pkg::IRQ_STATUS_ADDR;
	wire rdIrqMk  = s_axi_araddr == sfs_pkg::IRQ_MASK_ADDR;
	wire rdKnown  = rdStatus || rdTxLvl || rdRxLvl || rdSoft || rdShadow
		|| rdIrqSt || rdIrqMk;

	// fifo occupancy
	wire txFull  = txCount_r == TX_FULL_CNT;
	wire txEmpty = txCount_r == '0;
	wire rxFull  = rxCount_r == RX_FULL_CNT;
	wire rxEmpty = rxCount_r == '0;

	// fifo enable falling edge flushes both fifos
	wire fifoEnFall = fifoEnPrev_r && !fifoEnable;
	wire txFlushNow = ctlTxFlush || fifoEnFall
		|| (wrSoft && wData_r[sfs_pkg::TX_FLUSH_BIT]);
	wire rxFlushNow = ctlRxFlush || fifoEnFall
		|| (wrSoft && wData_r[sfs_pkg::RX_FLUSH_BIT]);

	wire txPushOk = txPush && !txFull;
	wire txPopOk  = txPop && !txEmpty;
	wire rxPushOk = rxPush && !rxFull;
	wire rxPopOk  = rxPop && !rxEmpty;

	always_comb begin
		txCount_nxt = txCount_r;
		if (txFlushNow) begin
			txCount_nxt = '0;
		end else if (txPushOk && !txPopOk) begin
			txCount_nxt = txCount_r + TXC_W'(1);
		end else if (txPopOk && !txPushOk) begin
			txCount_nxt = txCount_r - TXC_W'(1);
		end
	end

	always_comb begin
		rxCount_nxt = rxCount_r;
		if (rxFlushNow) begin
			rxCount_nxt = '0;
		end else if (rxPushOk && !rxPopOk) begin
			rxCount_nxt = rxCount_r + RXC_W'(1);
		end else if (rxPopOk && !rxPushOk) begin
			rxCount_nxt = rxCount_r - RXC_W'(1);
		end
	end

	// interrupt events, taken on the cycle the condition first appears
	wire rxFullEv  = (rxCount_nxt == RX_FULL_CNT) && !rxFull;
	wire txEmptyEv = (txCount_nxt == '0) && !txEmpty;
	wire rxOvfEv   = rxPush && rxFull && !rxPopOk;
	wire txOvfEv   = txPush && txFull && !txPopOk;
	wire [sfs_pkg::IRQ_W-1:0] irqEvents = {txOvfEv, rxOvfEv, txEmptyEv,
		rxFullEv};
	wire irqClear = doRead && rdIrqSt;

	// a new event beats the clear caused by reading the status
	always_comb begin
		irqStat_nxt = irqStat_r;
		if (irqClear) begin
			irqStat_nxt = '0;
		end
		irqStat_nxt = irqStat_nxt | irqEvents;
	end

	// status word seen by software
	wire [31:0] statusWord = 32'({rxFull, !rxEmpty, txEmpty, !txFull,
		1'h0});
	wire [31:0] txLvlWord = 32'(TX_LEVEL_VIEW(txCount_r));
	wire [31:0] rxLvlWord = 32'(RX_LEVEL_VIEW(rxCount_r));

	function automatic logic [sfs_pkg::TX_LEVEL_W-1:0] TX_LEVEL_VIEW(
		input logic [TXC_W-1:0] c);
		TX_LEVEL_VIEW = sfs_pkg::TX_LEVEL_W'(c);
	endfunction : TX_LEVEL_VIEW

	function automatic logic [sfs_pkg::RX_LEVEL_W-1:0] RX_LEVEL_VIEW(
		input logic [RXC_W-1:0] c);
		RX_LEVEL_VIEW = sfs_pkg::RX_LEVEL_W'(c);
	endfunction : RX_LEVEL_VIEW

	// write-only reset register and reserved bits read as zero
	wire [31:0] readWord =
		rdStatus ? statusWord :
		rdTxLvl  ? txLvlWord :
		rdRxLvl  ? rxLvlWord :
		rdShadow ? 32'(sendReq_r) :
		rdIrqSt  ? 32'(irqStat_r) :
		rdIrqMk  ? 32'(irqMask_r) :
		32'h00000000;

	// send request pin: loopback wins, then the threshold gate
	wire flowHold = autoFlowEnable && fifoEnable && rxAboveThreshold;
	wire sendReqN_nxt = loopbackEnable ? 1'h1 :
		flowHold ? 1'h1 :
		!sendReq_r;

	// controller reset: asserted at once, released through two flops
	wire ctrlArstN = reset_n && !softResetReq_r;

	always_ff @(posedge sys_clk or negedge ctrlArstN) begin
		if (!ctrlArstN) begin
			rstSync1_r <= 1'h0;
			rstSync2_r <= 1'h0;
		end else begin
			rstSync1_r <= 1'h1;
			rstSync2_r <= rstSync1_r;
		end
	end

	wire ctrlRstN = rstSync2_r;

	// soft reset request is a one-cycle pulse that clears itself
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			softResetReq_r <= 1'h0;
		end else begin
			softResetReq_r <= wrSoft
				&& wData_r[sfs_pkg::SOFT_RESET_BIT];
		end
	end

	// write address and data are taken in either order
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			awAddr_r <= 32'h00000000;
			awHeld_r <= 1'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awAddr_r <= s_axi_awaddr;
			awHeld_r <= 1'h1;
		end else if (doWrite) begin
			awHeld_r <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			wHeld_r <= 1'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
			wHeld_r <= 1'h1;
		end else if (doWrite) begin
			wHeld_r <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'h1;
			s_axi_wready  <= 1'h1;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= sfs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'h0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp  <= wrKnown ? sfs_pkg::RESP_OKAY
					: sfs_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready  <= 1'h1;
			end
		end
	end

	// read channel: one read at a time, answer one cycle after address
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= sfs_pkg::RESP_OKAY;
		end else if (doRead) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h1;
			s_axi_rdata   <= readWord;
			s_axi_rresp   <= rdKnown ? sfs_pkg::RESP_OKAY
				: sfs_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
		end
	end

	// controller state; modem control and shadow writes share one bit
	always_ff @(posedge sys_clk or negedge ctrlRstN) begin
		if (!ctrlRstN) begin
			txCount_r    <= '0;
			rxCount_r    <= '0;
			fifoEnPrev_r <= 1'h0;
			sendReq_r    <= sfs_pkg::SEND_REQ_RST;
			irqStat_r    <= sfs_pkg::IRQ_STAT_RST;
			irqMask_r    <= sfs_pkg::IRQ_MASK_RST;
		end else begin
			txCount_r    <= txCount_nxt;
			rxCount_r    <= rxCount_nxt;
			fifoEnPrev_r <= fifoEnable;
			irqStat_r    <= irqStat_nxt;
			if (wrShadow) begin
				sendReq_r <= wData_r[sfs_pkg::SEND_REQ_BIT];
			end else if (ctlSendReqWrite) begin
				sendReq_r <= ctlSendReqData;
			end
			if (wrMask) begin
				irqMask_r <= wData_r[sfs_pkg::IRQ_W-1:0];
			end
		end
	end

	// registered outputs toward the serial port
	always_ff @(posedge sys_clk or negedge ctrlRstN) begin
		if (!ctrlRstN) begin
			txFifoFlush     <= 1'h0;
			rxFifoFlush     <= 1'h0;
			sendRequestBit  <= sfs_pkg::SEND_REQ_RST;
			sendRequestN    <= 1'h1;
			loopSendRequest <= 1'h0;
			irq             <= 1'h0;
		end else begin
			txFifoFlush     <= txFlushNow;
			rxFifoFlush     <= rxFlushNow;
			sendRequestBit  <= sendReq_r;
			sendRequestN    <= sendReqN_nxt;
			loopSendRequest <= loopbackEnable && sendReq_r;
			irq             <= |(irqStat_nxt & irqMask_r);
		end
	end

	// controller reset seen by the rest of the port: asserted at once, released one cycle after ctrlRstN
	always_ff @(posedge sys_clk or negedge ctrlArstN) begin
		if (!ctrlArstN) begin
			controllerResetN <= 1'h0;
		end else begin
			controllerResetN <= ctrlRstN;
		end
	end
endmodule : sfs_serial_fifo_status
`default_nettype wire

// ==== tb/sfs_modem_model.sv ====
// modem model: sends characters only while send request is active
`timescale 1ns/1ns
`default_nettype none
module sfs_modem_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// bench control
	input  wire logic       start,
	input  wire logic [7:0] count,
	input  wire logic       slow,
	output logic            busy,
	// serial side
	input  wire logic       sendRequestN,
	output logic            rxPush
);
	logic [7:0] left_r;
	logic       gap_r;
	logic       go;
	assign busy = left_r != 8'h0;
	// holds off while the pin is high, as a real modem must
	assign go = busy & ~sendRequestN & ~gap_r & ~start;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			left_r <= 8'h0;
			gap_r  <= 1'h0;
			rxPush <= 1'h0;
		end else begin
			gap_r  <= slow & ~gap_r;
			rxPush <= go;
			left_r <= start ? count : left_r - {7'h0, go};
		end
	end
endmodule : sfs_modem_model
`default_nettype wire

// ==== tb/sfs_serial_fifo_status_asserts.sv ====
// port assertions for the fifo status block
`timescale 1ns/1ns
`default_nettype none
module sfs_status_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// control inputs
	input wire logic fifoEnable,
	input wire logic ctlTxFlush,
	input wire logic ctlRxFlush,
	input wire logic autoFlowEnable,
	input wire logic loopbackEnable,
	input wire logic rxAboveThreshold,
	// outputs
	input wire logic txFifoFlush,
	input wire logic rxFifoFlush,
	input wire logic controllerResetN,
	input wire logic sendRequestBit,
	input wire logic sendRequestN,
	input wire logic loopSendRequest
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_plain;
		!loopbackEnable && !autoFlowEnable && controllerResetN &&
			$stable(sendRequestBit);
	endsequence
	sequence s_looped;
		loopbackEnable && controllerResetN && $stable(sendRequestBit);
	endsequence
	chk_pin_follows: assert property (s_plain [*3] |->
		sendRequestN == !sendRequestBit) else $error("pin differs from bit");
	chk_auto_gate: assert property (!loopbackEnable && autoFlowEnable &&
		fifoEnable && rxAboveThreshold |=> sendRequestN)
		else $error("pin not gated by threshold");
	chk_loop_high: assert property (loopbackEnable |=> sendRequestN)
		else $error("pin driven in loopback");
	chk_loop_route: assert property (s_looped [*3] |->
		loopSendRequest == sendRequestBit) else $error("loop value wrong");
	chk_loop_idle: assert property (!loopbackEnable [*2] |->
		!loopSendRequest) else $error("looped out of loopback");
	chk_tx_flush: assert property (ctlTxFlush && controllerResetN |=>
		txFifoFlush) else $error("tx flush missing");
	chk_rx_flush: assert property (ctlRxFlush && controllerResetN |=>
		rxFifoFlush) else $error("rx flush missing");
	chk_enable_fall: assert property ($fell(fifoEnable) &&
		controllerResetN |=> txFifoFlush && rxFifoFlush)
		else $error("disable did not flush");
endmodule : sfs_status_asserts
bind sfs_serial_fifo_status sfs_status_asserts i_chk (.sys_clk, .reset_n,
	.fifoEnable, .ctlTxFlush, .ctlRxFlush, .autoFlowEnable, .loopbackEnable,
	.rxAboveThreshold, .txFifoFlush, .rxFifoFlush, .controllerResetN,
	.sendRequestBit, .sendRequestN, .loopSendRequest);
`default_nettype wire

// ==== tb/test_sfs_serial_fifo_status.sv ====
// self-checking bench for the fifo status block
`timescale 1ns/1ns
`default_nettype none
module test_sfs_serial_fifo_status;
	localparam int D = 16;
	localparam logic [31:0] ST = sfs_pkg::FIFO_STATUS_ADDR;
	localparam logic [31:0] TL = sfs_pkg::TX_FILL_LEVEL_ADDR;
	localparam logic [31:0] RL = sfs_pkg::RX_FILL_LEVEL_ADDR;
	localparam logic [31:0] SR = sfs_pkg::SOFT_RESET_ADDR;
	localparam logic [31:0] SH = sfs_pkg::SEND_REQ_SHADOW_ADDR;
	logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, txPush, txPop, rxPush;
	logic rxPop, fifoEnable, ctlTxFlush, ctlRxFlush, autoFlowEnable;
	logic loopbackEnable, ctlSendReqWrite, ctlSendReqData, rxAboveThreshold;
	logic txFifoFlush, rxFifoFlush, controllerResetN, sendRequestBit;
	logic sendRequestN, loopSendRequest, irq, mStart, mSlow, mBusy;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  mCount;
	logic [15:0] lfsr;
	int          fails, checks, txc, rxc;
	sfs_serial_fifo_status #(.TX_DEPTH(D), .RX_DEPTH(D)) i_dut (.sys_clk,
		.reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .txPush, .txPop, .rxPush, .rxPop,
		.fifoEnable, .ctlTxFlush, .ctlRxFlush, .autoFlowEnable,
		.loopbackEnable, .ctlSendReqWrite, .ctlSendReqData,
		.rxAboveThreshold, .txFifoFlush, .rxFifoFlush, .controllerResetN,
		.sendRequestBit, .sendRequestN, .loopSendRequest, .irq);
	sfs_modem_model i_modem (.sys_clk, .reset_n, .start(mStart),
		.count(mCount), .slow(mSlow), .busy(mBusy), .sendRequestN, .rxPush);
	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	function automatic logic [31:0] stat(input int t, x);
		return {27'h0, x == D, x != 0, t == 0, t != D, 1'h0};
	endfunction : stat
	task automatic stop_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic wr(input logic [31:0] a, v);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rdc(input logic [31:0] a, exp, input logic cmp = 1'h1);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		r = s_axi_rresp;
		if (cmp) check(s_axi_rdata, exp);
	endtask : rdc
	task automatic push_tx(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			txPush <= 1'h1;
		end
		@(posedge sys_clk);
		txPush <= 1'h0;
		txc = (txc + n > D) ? D : txc + n;
	endtask : push_tx
	task automatic push_rx(input int n, input logic slow);
		@(posedge sys_clk);
		{mStart, mSlow, mCount} <= {1'h1, slow, n[7:0]};
		@(posedge sys_clk);
		mStart <= 1'h0;
		@(posedge sys_clk);
		while (mBusy) @(posedge sys_clk);
		rxc = (rxc + n > D) ? D : rxc + n;
		tick(2);
	endtask : push_rx
	task automatic pops(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			{txPop, rxPop} <= 2'h3;
		end
		@(posedge sys_clk);
		{txPop, rxPop} <= 2'h0;
		txc = (txc > n) ? txc - n : 0;
		rxc = (rxc > n) ? rxc - n : 0;
	endtask : pops
	task automatic flush(input logic rxSide, viaFcr);
		if (viaFcr) begin
			@(posedge sys_clk);
			{ctlTxFlush, ctlRxFlush} <= {!rxSide, rxSide};
			@(posedge sys_clk);
			{ctlTxFlush, ctlRxFlush} <= 2'h0;
		end else
			wr(SR, rxSide ? 32'h2 : 32'h4);
		tick(2);
	endtask : flush
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, txPush, txPop, rxPop, ctlTxFlush, ctlRxFlush} = 6'h0;
		{autoFlowEnable, loopbackEnable, ctlSendReqWrite} = 3'h0;
		{ctlSendReqData, rxAboveThreshold, mStart, mSlow, reset_n} = 5'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{s_axi_wstrb, fifoEnable, mCount} = 13'h1F00;
		{lfsr, fails, checks, txc, rxc} = {16'h185B, 128'h0};
		tick(10);
		reset_n <= 1'h1;
		tick(3);
		rdc(ST, 32'h6);
		rdc(TL, 32'h0);
		rdc(RL, 32'h0);
		rdc(SR, 32'h0);
		check(r, sfs_pkg::RESP_OKAY);
		wr(SH, 32'hFFFE);
		rdc(SH, 32'h0);
		wr(SH, 32'hFFFF);
		check(r, sfs_pkg::RESP_OKAY);
		rdc(SH, 32'h1);
		tick(2);
		check(sendRequestN, 1'h0);
		@(posedge sys_clk);
		ctlSendReqWrite <= 1'h1;
		@(posedge sys_clk);
		ctlSendReqWrite <= 1'h0;
		tick(2);
		check(sendRequestN, 1'h1);
		rdc(SH, 32'h0);
		wr(SH, 32'h1);
		wr(sfs_pkg::IRQ_MASK_ADDR, 32'h1);
		rdc(sfs_pkg::IRQ_STATUS_ADDR, 32'h0, 1'h0);
		push_tx(D + 1);
		push_rx(D + 1, 1'h0);
		check(irq, 1'h1);
		rdc(ST, stat(txc, rxc));
		rdc(sfs_pkg::IRQ_STATUS_ADDR, 32'hD);
		tick(2);
		check(irq, 1'h0);
		wr(TL, 32'hFF);
		rdc(TL, D);
		wr(32'h50001000, 32'h1);
		check(r, sfs_pkg::RESP_SLVERR);
		rdc(32'h50001000, 32'h0);
		check(r, sfs_pkg::RESP_SLVERR);
		pops(5);
		rdc(RL, rxc);
		@(posedge sys_clk);
		fifoEnable <= 1'h0;
		@(posedge sys_clk);
		fifoEnable <= 1'h1;
		{txc, rxc} = 64'h0;
		rdc(ST, stat(0, 0));
		for (int i = 0; i < 6; i++) begin
			lfsr = nx(lfsr);
			push_tx(lfsr[3:0]);
			push_rx(lfsr[7:4], lfsr[8]);
			pops(lfsr[10:9]);
			rdc(ST, stat(txc, rxc));
			rdc(TL, txc);
			flush(1'h0, i[0]);
			rdc(RL, rxc);
			rdc(TL, 32'h0);
			flush(1'h1, i[0]);
			{txc, rxc} = 64'h0;
			rdc(RL, 32'h0);
		end
		@(posedge sys_clk);
		{autoFlowEnable, rxAboveThreshold} <= 2'h3;
		tick(2);
		check(sendRequestN, 1'h1);
		fifoEnable <= 1'h0;
		tick(2);
		check(sendRequestN, 1'h0);
		{fifoEnable, rxAboveThreshold} <= 2'h2;
		tick(2);
		check(sendRequestN, 1'h0);
		{autoFlowEnable, loopbackEnable} <= 2'h1;
		tick(4);
		check(sendRequestN, 1'h1);
		check(loopSendRequest, 1'h1);
		loopbackEnable <= 1'h0;
		push_tx(3);
		wr(SR, 32'h1);
		for (int k = 0; k < 8 && controllerResetN === 1'h1; k++) tick(1);
		check(controllerResetN, 1'h0);
		tick(6);
		check(controllerResetN, 1'h1);
		rdc(TL, 32'h0);
		rdc(SH, 32'h0);
		stop_test();
	end
endmodule : test_sfs_serial_fifo_status
`default_nettype wire
